//--- vpd_dispatch_core.sv
// Notes on behaviour
// - Fetch 256-bit packets of eight instructions.
// - Lowest bit one chains; zero closes packet.
// - Execute packet holds one to eight instructions.
// - Execute packets may span fetch packets.
// - Issue one execute packet per cycle.
// - Fetch only after current packets dispatched.
// - Units without instruction idle, others proceed.
// - Two files of thirty-two 32-bit registers.
// - Own-side units all read same cycle.
// - Non-address units may take second operand cross-side.
// - Stall once on cross read of fresh register.
// - Only address units reach memory, either file.
// - Byte, half, word, doubleword per access.
// - Words and doublewords at any byte.
// - Linear or circular, 5 or 15-bit offsets.
// - False condition changes no state.
// - Multiply: two 16x16 or four 8x8.
// - Logic units: 32, dual 16, quad 8.
`timescale 1ns/1ps
`include "vpd_params.svh"

module vpd_dispatch_core (
  input wire logic mclk,
  input wire logic srst,
  output logic pm_req,
  output logic [31:0] pm_addr,
  input wire logic pm_valid,
  input wire logic [255:0] pm_data,
  output vpd_pkg::vpd_dreq_t [1:0] dm_req,
  input wire logic [1:0][63:0] dm_rdata,
  output logic [7:0] unit_active,
  output logic xpath_stall
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  vpd_pkg::vpd_inst_t q_r [`VPD_Q_DEPTH];  // Undispatched instructions
  logic [4:0] q_cnt_r;                     // Entries held in queue
  vpd_pkg::vpd_fstate_t fst_r;             // Fetch state
  logic pm_req_r;                          // Fetch request level
  logic [31:0] pm_addr_r;                  // Fetch packet address
  vpd_pkg::vpd_inst_t ex_inst_r [8];       // Execute stage per unit
  logic [7:0] ex_vld_r;                    // Units busy this cycle
  logic [31:0] rf_r [2][`VPD_NREG];        // Register files per side
  logic [31:0] wmask_r [2];                // Registers written last edge
  logic stalled_r;                         // Previous cycle stalled
  vpd_pkg::vpd_dreq_t [1:0] dm_req_r;      // Memory requests
  vpd_pkg::vpd_ld_t ld1_r [2];             // Load with request out
  vpd_pkg::vpd_ld_t ld2_r [2];             // Load with data in

  // Combinational
  logic have_ep;
  logic [3:0] ep_len;
  logic need_fetch;
  logic fetch_done;
  logic stall;
  logic disp_go;
  vpd_pkg::vpd_inst_t rt_inst [8];
  logic [7:0] rt_vld;
  logic [31:0] opa [8];
  logic [31:0] opb [8];
  logic [31:0] alu_y [4];
  logic [9:0] w_en;
  logic w_side [10];
  logic [4:0] w_reg [10];
  logic [63:0] w_dat [10];
  logic w_pair [10];
  logic [31:0] wmask_nxt [2];
  vpd_pkg::vpd_dreq_t [1:0] dm_nxt;
  vpd_pkg::vpd_ld_t ld_nxt [2];

  assign pm_req = pm_req_r;
  assign pm_addr = pm_addr_r;
  assign dm_req = dm_req_r;
  assign unit_active = ex_vld_r;
  assign xpath_stall = stalled_r;
  assign fetch_done = (fst_r == vpd_pkg::FS_WAIT) && pm_valid;
  assign disp_go = have_ep && !stall;
  assign need_fetch = !have_ep;

  // --------------------------------------------------------------------
  // Execute packet scan
  // --------------------------------------------------------------------
  // First closing chain bit within eight entries; an unclosed run that
  // reaches the queue end waits for the next fetch packet.
  always_comb begin
    have_ep = 1'b0;
    ep_len = 4'h0;
    for (int i = 0; i < `VPD_EP_MAX; i++) begin
      if (!have_ep && 5'(i) < q_cnt_r &&
          (!q_r[i].chain || i == `VPD_EP_MAX - 1)) begin
        have_ep = 1'b1;
        ep_len = 4'(i + 1);
      end
    end
  end

  // Route packet slots to their units; absent units stay idle
  always_comb begin
    for (int u = 0; u < 8; u++) begin
      rt_inst[u] = '0;
      rt_vld[u] = 1'b0;
    end
    for (int i = 0; i < `VPD_EP_MAX; i++) begin
      if (4'(i) < ep_len) begin
        rt_inst[q_r[i].unit] = q_r[i];
        rt_vld[q_r[i].unit] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Fetch control
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      fst_r <= vpd_pkg::FS_HAVE;
      pm_req_r <= 1'b0;
      pm_addr_r <= `VPD_RESET_ADDR;
    end else begin
      case (fst_r)
        vpd_pkg::FS_HAVE: begin
          // Only once no complete packet remains
          if (need_fetch) begin
            pm_req_r <= 1'b1;
            fst_r <= vpd_pkg::FS_WAIT;
          end
        end
        vpd_pkg::FS_WAIT: begin
          if (pm_valid) begin
            pm_req_r <= 1'b0;
            pm_addr_r <= pm_addr_r + `VPD_FP_BYTES;
            fst_r <= vpd_pkg::FS_HAVE;
          end
        end
        default: begin
          fst_r <= vpd_pkg::FS_HAVE;
          pm_req_r <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Instruction queue
  // --------------------------------------------------------------------
  // A spanning remainder sits at the head; new slots append behind it,
  // so the whole packet later leaves in one cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      q_cnt_r <= 5'h0;
      for (int i = 0; i < `VPD_Q_DEPTH; i++) begin
        q_r[i] <= '0;
      end
    end else if (fetch_done) begin
      for (int j = 0; j < `VPD_FP_SLOTS; j++) begin
        q_r[q_cnt_r[3:0] + 4'(j)] <= pm_data[32*j +: 32];
      end
      q_cnt_r <= q_cnt_r + 5'(`VPD_FP_SLOTS);
    end else if (disp_go) begin
      for (int i = 0; i < `VPD_Q_DEPTH; i++) begin
        if (i + int'(ep_len) < `VPD_Q_DEPTH) begin
          q_r[i] <= q_r[i + int'(ep_len)];
        end else begin
          q_r[i] <= '0;
        end
      end
      q_cnt_r <= q_cnt_r - {1'b0, ep_len};
    end
  end

  // --------------------------------------------------------------------
  // Execute stage and cross-path interlock
  // --------------------------------------------------------------------
  // Cross read of a register written at the last edge waits one cycle;
  // the stalled_r term keeps a second stall from following at once.
  always_comb begin
    stall = 1'b0;
    for (int u = 0; u < 8; u++) begin
      if (ex_vld_r[u] && ex_inst_r[u].xpath && u % 4 != 3 && !stalled_r &&
          wmask_r[u < 4 ? 1 : 0][ex_inst_r[u].src2]) begin
        stall = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ex_vld_r <= 8'h0;
      for (int u = 0; u < 8; u++) begin
        ex_inst_r[u] <= '0;
      end
    end else if (!stall) begin
      ex_vld_r <= disp_go ? rt_vld : 8'h0;
      for (int u = 0; u < 8; u++) begin
        ex_inst_r[u] <= rt_inst[u];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stalled_r <= 1'b0;
    end else begin
      stalled_r <= stall;
    end
  end

  // --------------------------------------------------------------------
  // Operands, condition and unit results
  // --------------------------------------------------------------------
  always_comb begin
    for (int d = 0; d < 10; d++) begin
      w_en[d] = 1'b0;
      w_side[d] = 1'b0;
      w_reg[d] = 5'h0;
      w_dat[d] = 64'h0;
      w_pair[d] = 1'b0;
    end
    for (int d = 0; d < 2; d++) begin
      dm_nxt[d] = '0;
      ld_nxt[d] = '0;
    end
    for (int u = 0; u < 8; u++) begin
      logic sd;
      logic cond;
      logic [31:0] base;
      logic [31:0] lin;
      logic [14:0] off;
      logic ds;
      vpd_pkg::vpd_inst_t ins;
      ins = ex_inst_r[u];
      sd = (u >= 4);
      base = 32'h0;
      lin = 32'h0;
      off = 15'h0;
      ds = 1'b0;
      cond = 1'b0;
      opa[u] = rf_r[sd][ins.src1];
      opb[u] = ins.xpath ? rf_r[!sd][ins.src2] : rf_r[sd][ins.src2];
      cond = (ins.creg == 2'h0) ||
             ((rf_r[sd][{3'h0, ins.creg}] != 32'h0) ^ ins.z);
      if (ex_vld_r[u] && cond && !stall) begin
        w_side[u] = sd;
        w_reg[u] = ins.dst;
        case (u % 4)
          0, 1: begin
            w_en[u] = 1'b1;
            w_dat[u] = {32'h0, alu_y[(u / 4) * 2 + u % 4]};
          end
          2: begin
            w_en[u] = 1'b1;
            w_pair[u] = 1'b1;
            if (ins.op[0]) begin
              for (int k = 0; k < 4; k++) begin
                w_dat[u][16*k +: 16] = {8'h0, opa[u][8*k +: 8]} *
                                       {8'h0, opb[u][8*k +: 8]};
              end
            end else begin
              for (int k = 0; k < 2; k++) begin
                w_dat[u][32*k +: 32] = {16'h0, opa[u][16*k +: 16]} *
                  {16'h0, opb[u][16*k +: 16]};
              end
            end
          end
          default: begin
            ds = ins.xpath ? !sd : sd;
            if (ins.long_off) begin
              base = rf_r[sd][`VPD_LONG_BASE];
              off = {ins.off_hi, ins.src1, ins.src2};
            end else begin
              base = opa[u];
              off = {10'h0, ins.src2};
            end
            lin = base + {17'h0, off};
            // Circular bases wrap inside a fixed power-of-two block
            if (!ins.long_off && ins.src1 >= `VPD_CIRC_LO &&
                ins.src1 <= `VPD_CIRC_HI) begin
              lin = {base[31:`VPD_CIRC_LOG2],
                     lin[`VPD_CIRC_LOG2-1:0]};
            end
            dm_nxt[u / 4].vld = 1'b1;
            dm_nxt[u / 4].we = ins.op[2];
            dm_nxt[u / 4].size = vpd_pkg::vpd_size_t'(ins.op[1:0]);
            dm_nxt[u / 4].addr = lin;
            dm_nxt[u / 4].wdata = {rf_r[ds][ins.dst + 5'h1],
                                   rf_r[ds][ins.dst]};
            ld_nxt[u / 4].vld = !ins.op[2];
            ld_nxt[u / 4].side = ds;
            ld_nxt[u / 4].dst = ins.dst;
            ld_nxt[u / 4].size = vpd_pkg::vpd_size_t'(ins.op[1:0]);
          end
        endcase
      end
    end
    // Load returns, zero-extended to the register
    for (int d = 0; d < 2; d++) begin
      w_en[8 + d] = ld2_r[d].vld;
      w_side[8 + d] = ld2_r[d].side;
      w_reg[8 + d] = ld2_r[d].dst;
      w_pair[8 + d] = (ld2_r[d].size == vpd_pkg::SZ_DWORD);
      case (ld2_r[d].size)
        vpd_pkg::SZ_BYTE: w_dat[8 + d] = {56'h0, dm_rdata[d][7:0]};
        vpd_pkg::SZ_HALF: w_dat[8 + d] = {48'h0, dm_rdata[d][15:0]};
        vpd_pkg::SZ_WORD: w_dat[8 + d] = {32'h0, dm_rdata[d][31:0]};
        default: w_dat[8 + d] = dm_rdata[d];
      endcase
    end
    wmask_nxt[0] = 32'h0;
    wmask_nxt[1] = 32'h0;
    for (int d = 0; d < 10; d++) begin
      if (w_en[d]) begin
        wmask_nxt[w_side[d]][w_reg[d]] = 1'b1;
        if (w_pair[d]) begin
          wmask_nxt[w_side[d]][w_reg[d] + 5'h1] = 1'b1;
        end
      end
    end
  end

  // Logic and shift units have one packed adder each
  for (genvar k = 0; k < 4; k++) begin : g_alu
    vpd_simd_alu u_alu (
      .a(opa[(k / 2) * 4 + k % 2]),
      .b(opb[(k / 2) * 4 + k % 2]),
      .op(vpd_pkg::vpd_alu_op_t'(ex_inst_r[(k / 2) * 4 + k % 2].op)),
      .y(alu_y[k])
    );
  end

  // --------------------------------------------------------------------
  // Register files; later writer wins a same-register clash
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int d = 0; d < 10; d++) begin
      if (w_en[d]) begin
        rf_r[w_side[d]][w_reg[d]] <= w_dat[d][31:0];
        if (w_pair[d]) begin
          rf_r[w_side[d]][w_reg[d] + 5'h1] <= w_dat[d][63:32];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wmask_r[0] <= 32'h0;
      wmask_r[1] <= 32'h0;
    end else begin
      wmask_r <= wmask_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Data memory request and load tracking
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      dm_req_r <= '0;
      ld1_r[0] <= '0;
      ld1_r[1] <= '0;
      ld2_r[0] <= '0;
      ld2_r[1] <= '0;
    end else begin
      dm_req_r <= dm_nxt;
      ld1_r <= ld_nxt;
      ld2_r <= ld1_r;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_fetch_in;
    fst_r == vpd_pkg::FS_WAIT && pm_valid;
  endsequence

  property p_fetch_append;
    s_fetch_in |=> q_cnt_r == $past(q_cnt_r) + 5'h8;
  endproperty
  a_fetch_append: assert property (p_fetch_append)
    else $error("fetch packet did not add eight slots");

  property p_ep_size;
    disp_go |-> ep_len >= 4'h1 && ep_len <= 4'h8;
  endproperty
  a_ep_size: assert property (p_ep_size)
    else $error("execute packet size out of range");

  property p_close_bit;
    disp_go && ep_len < 4'h8 |-> !q_r[ep_len - 4'h1].chain;
  endproperty
  a_close_bit: assert property (p_close_bit)
    else $error("packet closed on a chained slot");

  property p_fetch_gate;
    $rose(pm_req_r) |-> $past(need_fetch);
  endproperty
  a_fetch_gate: assert property (p_fetch_gate)
    else $error("fetch requested with packets pending");

  property p_shift;
    disp_go |=> q_cnt_r == $past(q_cnt_r) - {1'b0, $past(ep_len)} &&
                ex_vld_r != 8'h0;
  endproperty
  a_shift: assert property (p_shift)
    else $error("dispatch did not retire the packet");

  property p_span_hold;
    need_fetch && q_cnt_r != 5'h0 |-> !disp_go ##1 q_cnt_r != 5'h0;
  endproperty
  a_span_hold: assert property (p_span_hold)
    else $error("spanning remainder lost");

  sequence s_stall_pair;
    stall ##1 (stalled_r && !stall);
  endsequence

  property p_xstall;
    stall |-> s_stall_pair ##0 $stable(ex_vld_r);
  endproperty
  a_xstall: assert property (p_xstall)
    else $error("cross path stall not exactly one cycle");

  property p_cond_false;
    ex_vld_r[3] && ex_inst_r[3].creg != 2'h0 && !stall &&
    ((rf_r[0][{3'h0, ex_inst_r[3].creg}] != 32'h0) == ex_inst_r[3].z)
    |=> !dm_req_r[0].vld;
  endproperty
  a_cond_false: assert property (p_cond_false)
    else $error("false condition reached memory");

  property p_reset;
    disable iff (1'b0) srst |=> q_cnt_r == 5'h0 && !pm_req_r &&
      pm_addr_r == `VPD_RESET_ADDR && ex_vld_r == 8'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear dispatch state");

endmodule : vpd_dispatch_core

//--- vpd_params.svh
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH

// ----------------------------------------------------------------------
// Fetch and queue geometry
// ----------------------------------------------------------------------
`define VPD_FP_BITS 256
`define VPD_FP_SLOTS 8
`define VPD_FP_BYTES 32'h0000_0020
`define VPD_EP_MAX 8
`define VPD_Q_DEPTH 16
`define VPD_RESET_ADDR 32'h0000_0000

// ----------------------------------------------------------------------
// Register files and addressing
// ----------------------------------------------------------------------
`define VPD_NREG 32
`define VPD_LONG_BASE 5'h0F
`define VPD_CIRC_LO 5'h04
`define VPD_CIRC_HI 5'h07
`define VPD_CIRC_LOG2 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define VPD_CLK_NS 8
`define VPD_XSTALL_CLKS 1

`endif

//--- vpd_pkg.sv
package vpd_pkg;

  // --------------------------------------------------------------------
  // Instruction word, chaining flag in the lowest bit
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] off_hi;   // Upper bits of long offset
    logic long_off;       // Long offset from fixed base register
    logic [1:0] creg;     // Condition register, zero means always
    logic z;              // Invert condition test
    logic [2:0] op;       // Unit opcode
    logic [4:0] src2;     // Second operand or short offset
    logic [4:0] src1;     // First operand or base
    logic [4:0] dst;      // Destination or store source
    logic xpath;          // Operand or data from opposite side
    logic [2:0] unit;     // Target functional unit
    logic chain;          // One joins next instruction
  } vpd_inst_t;

  // --------------------------------------------------------------------
  // Functional units, side in the top bit
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    logic_unit_side_a = 3'h0,
    shift_branch_unit_side_a = 3'h1,
    multiply_unit_side_a = 3'h2,
    data_address_unit_side_a = 3'h3,
    logic_unit_side_b = 3'h4,
    shift_branch_unit_side_b = 3'h5,
    multiply_unit_side_b = 3'h6,
    data_address_unit_side_b = 3'h7
  } vpd_unit_t;

  // Arithmetic and logic opcodes
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_ADD2 = 3'h1, ALU_ADD4 = 3'h2, ALU_SUB = 3'h3,
    ALU_SUB2 = 3'h4, ALU_SUB4 = 3'h5, ALU_AND = 3'h6, ALU_XOR = 3'h7
  } vpd_alu_op_t;

  // Access sizes of data-addressing units
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2, SZ_DWORD = 2'h3
  } vpd_size_t;

  // Fetch state, one-hot
  typedef enum logic [1:0] {
    FS_HAVE = 2'h1,
    FS_WAIT = 2'h2
  } vpd_fstate_t;

  // Data memory request
  typedef struct packed {
    logic vld;
    logic we;
    vpd_size_t size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } vpd_dreq_t;

  // Pending load writeback
  typedef struct packed {
    logic vld;
    logic side;
    logic [4:0] dst;
    vpd_size_t size;
  } vpd_ld_t;

endpackage : vpd_pkg

//--- vpd_simd_alu.sv
`timescale 1ns/1ps

module vpd_simd_alu (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire vpd_pkg::vpd_alu_op_t op,
  output logic [31:0] y
);

  // --------------------------------------------------------------------
  // Byte-sliced adder; carry broken at lane edges for packed forms
  // --------------------------------------------------------------------
  always_comb begin
    logic [31:0] bb;
    logic [31:0] sum;
    logic [8:0] s;
    logic sub;
    logic quad;
    logic dual;
    logic carry;
    logic cin;
    bb = 32'h0;
    sum = 32'h0;
    s = 9'h0;
    carry = 1'b0;
    cin = 1'b0;
    sub = (op == vpd_pkg::ALU_SUB) || (op == vpd_pkg::ALU_SUB2) ||
          (op == vpd_pkg::ALU_SUB4);
    quad = (op == vpd_pkg::ALU_ADD4) || (op == vpd_pkg::ALU_SUB4);
    dual = (op == vpd_pkg::ALU_ADD2) || (op == vpd_pkg::ALU_SUB2);
    bb = sub ? ~b : b;
    for (int i = 0; i < 4; i++) begin
      // Lane start takes the subtract carry-in instead of the chain
      if (i == 0 || quad || (dual && i == 2)) begin
        cin = sub;
      end else begin
        cin = carry;
      end
      s = {1'b0, a[8*i +: 8]} + {1'b0, bb[8*i +: 8]} + {8'h0, cin};
      sum[8*i +: 8] = s[7:0];
      carry = s[8];
    end
    case (op)
      vpd_pkg::ALU_AND: y = a & b;
      vpd_pkg::ALU_XOR: y = a ^ b;
      default: y = sum;
    endcase
  end

endmodule : vpd_simd_alu

//--- vpd_pmem_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Program memory model, answers fetch requests after lat idle cycles
// ----------------------------------------------------------------------
module vpd_pmem_model (
  input wire logic mclk,
  input wire logic pm_req,
  input wire logic [31:0] pm_addr,
  input wire logic [3:0] lat,
  output logic pm_valid,
  output logic [255:0] pm_data
);
  logic [255:0] mem [0:15]; // Sixteen fetch packets, filled by the bench
  logic [3:0] cnt_r; // Cycles waited on the open request

  initial begin
    pm_valid = 1'b0;
    pm_data = '0;
    cnt_r = 4'h0;
  end

  // Wait counter, cleared whenever no request is pending
  always @(posedge mclk) begin
    if (pm_req && !pm_valid) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      cnt_r <= 4'h0;
    end
  end

  // One-cycle answer; data toggles outside it so stale bits never match
  always @(posedge mclk) begin
    if (pm_req && !pm_valid && cnt_r >= lat) begin
      pm_valid <= 1'b1;
      pm_data <= mem[pm_addr[8:5]];
    end else begin
      pm_valid <= 1'b0;
      pm_data <= ~pm_data;
    end
  end
endmodule : vpd_pmem_model

//--- vpd_dispatch_core_tb.sv
`timescale 1ns/1ps

module vpd_dispatch_core_tb;
  // --------------------------------------------------------------------
  // Design and partner wiring
  // --------------------------------------------------------------------
  logic mclk, srst, pm_req, pm_valid, xpath_stall;
  logic [31:0] pm_addr;
  logic [255:0] pm_data;
  vpd_pkg::vpd_dreq_t [1:0] dm_req;
  logic [1:0][63:0] dm_rdata; // Constant load data, lands as value one
  logic [7:0] unit_active;
  logic [3:0] lat; // Memory latency, prompt or slow
  int n_fail = 0;
  int checks = 0;
  logic [7:0] ua_q [$]; // Issued unit sets in order
  logic pr_q [$]; // Fetch request seen beside each issue
  logic [2:0] dq [$]; // Side A accesses as {we, size}
  int nst, nb; // Stall marks, side B accesses
  logic [31:0] da; // Address of the last side A store

  vpd_dispatch_core dut (.mclk(mclk), .srst(srst), .pm_req(pm_req),
    .pm_addr(pm_addr), .pm_valid(pm_valid), .pm_data(pm_data),
    .dm_req(dm_req), .dm_rdata(dm_rdata), .unit_active(unit_active),
    .xpath_stall(xpath_stall));
  vpd_pmem_model pm (.mclk(mclk), .pm_req(pm_req), .pm_addr(pm_addr),
    .lat(lat), .pm_valid(pm_valid), .pm_data(pm_data));

  always #4 mclk = ~mclk;

  // --------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] ins(input logic [2:0] u, input logic c,
      input logic x = 1'b0, input logic [4:0] d = 5'h00,
      input logic [4:0] s = 5'h00, input logic [2:0] op = 3'h0,
      input logic [1:0] cr = 2'h0, input logic z = 1'b0,
      input logic [4:0] a = 5'h00);
    // Second operand s above first operand or base a
    return {6'h00, cr, z, op, s, a, d, x, u, c};
  endfunction : ins

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
        exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic put(input int f, input int j, input logic [31:0] w);
    pm.mem[f][32*j +: 32] = w;
  endtask : put

  // Every packet a single filler on the side A shift unit
  task automatic clr;
    for (int f = 0; f < 16; f++) begin
      for (int j = 0; j < 8; j++) begin
        put(f, j, ins(3'h1, 1'b0));
      end
    end
  endtask : clr

  // Three reset edges, then the cleared state
  task automatic do_reset;
    @(posedge mclk) srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk(pm_req, 1'b0);
    chk(pm_addr, 32'h0);
    chk(unit_active, 8'h00);
    chk(dm_req[0].vld, 1'b0);
    chk(xpath_stall, 1'b0);
  endtask : do_reset

  // Record n issues plus a short tail; bounded against a hang
  task automatic run(input int n);
    int tail;
    ua_q = {};
    pr_q = {};
    dq = {};
    nst = 0;
    nb = 0;
    da = 32'h0;
    tail = 0;
    for (int i = 0; i < 300 && tail < 4; i++) begin
      @(posedge mclk);
      #1;
      if (unit_active !== 8'h00) begin
        ua_q.push_back(unit_active);
        pr_q.push_back(pm_req);
      end
      if (xpath_stall === 1'b1) nst++;
      if (dm_req[0].vld === 1'b1) dq.push_back({dm_req[0].we,
        dm_req[0].size});
      if (dm_req[1].vld === 1'b1) nb++;
      if (dm_req[0].vld === 1'b1 && dm_req[0].we === 1'b1) begin
        da = dm_req[0].addr;
      end
      if (ua_q.size() >= n) tail++;
    end
    if (ua_q.size() < n) begin
      n_fail++;
      conclude();
    end
  endtask : run

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Mixed packet sizes, a packet spanning two fetches, eight singles
  task automatic t_split(input logic [3:0] l);
    logic [7:0] ex [14];
    logic [13:0] lo; // Issues where a fetch must not be pending
    ex = '{8'h11, 8'h04, 8'h68, 8'h02, 8'h81, 8'hFE, 8'h01, 8'h02, 8'h04,
      8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    lo = 14'b0_1111111_0_1_0_111;
    clr();
    put(0, 0, ins(3'h0, 1'b1));
    put(0, 1, ins(3'h4, 1'b0));
    put(0, 2, ins(3'h2, 1'b0));
    put(0, 3, ins(3'h3, 1'b1));
    put(0, 4, ins(3'h5, 1'b1));
    put(0, 5, ins(3'h6, 1'b0));
    put(0, 7, ins(3'h7, 1'b1));
    for (int j = 0; j < 8; j++) begin
      put(1, j, ins(3'(j), j != 0 && j != 7));
      put(2, j, ins(3'(j), 1'b0));
    end
    @(posedge mclk) lat <= l;
    do_reset();
    run(14);
    foreach (ex[i]) begin
      chk(ua_q[i], ex[i]);
      if (lo[i]) chk(pr_q[i], 1'b0);
    end
    chk(ua_q[4], 8'h81);
  endtask : t_split

  // Fresh register read across sides stalls once; older one does not
  task automatic t_stall;
    int k;
    k = 0;
    clr();
    put(0, 0, ins(3'h0, 1'b0, 1'b0, 5'h01));
    put(0, 1, ins(3'h4, 1'b0, 1'b1, 5'h00, 5'h01));
    put(0, 2, ins(3'h0, 1'b0, 1'b0, 5'h02));
    put(0, 4, ins(3'h4, 1'b0, 1'b1, 5'h00, 5'h02));
    put(0, 6, ins(3'h4, 1'b1, 1'b1, 5'h00, 5'h03));
    put(0, 7, ins(3'h6, 1'b0, 1'b1, 5'h00, 5'h03));
    do_reset();
    run(7);
    foreach (ua_q[i]) if (ua_q[i] === 8'h50) k++;
    chk(64'(nst), 64'h1);
    chk(64'(k), 64'h1);
  endtask : t_stall

  // Load sets a condition register; true store issues, false does not
  task automatic t_mem;
    clr();
    put(0, 0, ins(3'h3, 1'b0, 1'b0, 5'h01, 5'h00, 3'h2));
    put(0, 5, ins(3'h3, 1'b0, 1'b0, 5'h02, 5'h05, 3'h7, 2'h1, 1'b0, 5'h01));
    put(0, 6, ins(3'h3, 1'b0, 1'b0, 5'h02, 5'h00, 3'h6, 2'h1, 1'b1));
    do_reset();
    run(8);
    chk(64'(dq.size()), 64'h2);
    chk(dq[0], {1'b0, vpd_pkg::SZ_WORD});
    chk(dq[1], {1'b1, vpd_pkg::SZ_DWORD});
    chk(64'(nb), 64'h0);
    chk(da, 32'h6);
  endtask : t_mem

  // Reset during a slow second fetch restarts from address zero
  task automatic t_reset;
    clr();
    put(0, 0, ins(3'h5, 1'b0));
    do_reset();
    run(1);
    chk(ua_q[0], 8'h20);
    @(posedge mclk) lat <= 4'hC;
    #1;
    for (int i = 0; i < 100 && !(pm_req === 1'b1 && pm_addr !== 32'h0);
        i++) begin
      @(posedge mclk);
      #1;
    end
    // Second fetch never opened: count it and stop
    if (!(pm_req === 1'b1 && pm_addr !== 32'h0)) begin
      n_fail++;
      conclude();
    end
    do_reset();
    @(posedge mclk) lat <= 4'h0;
    run(1);
    chk(ua_q[0], 8'h20);
  endtask : t_reset

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    lat = 4'h0;
    dm_rdata = {64'h1, 64'h1};
    t_split(4'h0);
    t_split(4'h6);
    t_stall();
    t_mem();
    t_reset();
    conclude();
  end
endmodule : vpd_dispatch_core_tb
